// ### src/ssp_pkg.sv
// package: register map, field layout and codes for the stop, pin-mux and arbitration control block
package ssp_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_CLK_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_PIN_SEL     = 8'h04;
    localparam logic [7:0]  OFS_DEF_MASTER  = 8'h0c;
    localparam logic [7:0]  OFS_STATUS      = 8'h10;
    localparam logic [7:0]  OFS_ARB_IN      = 8'h14;
    localparam int          PIN_W           = 16;
    localparam int          DM_W            = 8;
    localparam logic [7:0]  DM_RESET        = 8'h00;
    localparam logic [7:0]  DM_WMASK        = 8'hf9;
    localparam int          DM_PARK_HI      = 7;
    localparam int          DM_PARK_LO      = 6;
    localparam int          DM_IARB         = 5;
    localparam int          DM_EARB         = 4;
    localparam int          DM_SHOW         = 3;
    localparam int          DM_CNT24        = 0;
    localparam int          CC_STOP_EN      = 0;
    localparam int          CC_WAKE_LO      = 1;
    localparam int          CC_WAKE_HI      = 3;
    localparam logic [2:0]  WAKE_ANY        = 3'h0;
    localparam logic [2:0]  WAKE_NONE       = 3'h7;
    localparam logic [2:0]  BW_MAX          = 3'h0;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
    typedef enum logic [1:0] {
        SSP_PARK_RR   = 2'h0,
        SSP_PARK_CORE = 2'h1,
        SSP_PARK_DMA  = 2'h2,
        SSP_PARK_CUR  = 2'h3
    } ssp_park_t;
    typedef enum {SSP_OWN_CORE, SSP_OWN_DMA, SSP_OWN_EXT} ssp_own_t;
endpackage : ssp_pkg

// ### src/ssp_ctrl.sv
// stop gating, pin-function select and internal bus arbiter with an ahb-lite register slave
// Contract
// - stop acknowledged only when enable set
// - stop enable resets to zero
// - stop gates only the core clock
// - wake threshold decodes any, 2-7 ... 7, none
// - qualifying interrupt restores core clock
// - pin select bit chooses port or alternate
// - pin select reset value from strap
// - arbitrate core, dma and external masters
// - park field selects four schemes
// - default master register 8 bits, reset zero
// - internal arbitration bit admits external masters
// - dma maximum bandwidth beats the core
// - negated external grant ranks external highest
// - register-space arbitration bit routes registers external
// - module base register core-only
// - round robin alternates while both request
// - park core/dma grants other only when idle
// - park current keeps owner while requesting
// - show data needs register-space arbitration
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
module ssp_ctrl
    import ssp_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                clk_en,
    input  wire logic                hsel,
    input  wire logic [ADDR_W-1:0]   haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                stop_request,
    output logic                     stop_ack,
    output logic                     core_clk_enable,
    input  wire logic [2:0]          irq_level,
    output logic                     wake_event,
    input  wire logic                config_strap_pin,
    output logic      [PIN_W-1:0]    pin_select,
    output logic      [PIN_W-1:0]    port_pins_out,
    output logic      [PIN_W-1:0]    port_pins_oe,
    input  wire logic [PIN_W-1:0]    port_pins_in,
    input  wire logic [PIN_W-1:0]    alt_func_out,
    input  wire logic [PIN_W-1:0]    alt_func_dir,
    input  wire logic [PIN_W-1:0]    gpio_out,
    input  wire logic [PIN_W-1:0]    gpio_dir,
    output logic      [PIN_W-1:0]    alt_func_in,
    output logic      [PIN_W-1:0]    gpio_in,
    input  wire logic                core_req,
    input  wire logic                dma_req,
    input  wire logic [2:0]          dma_bandwidth_field,
    input  wire logic                bus_busy,
    input  wire logic                external_grant_in,
    input  wire logic                ext_targets_internal,
    input  wire logic                ext_targets_module_base_register,
    output logic                     core_grant,
    output logic                     dma_grant,
    output logic                     ext_grant,
    output logic                     reg_access_external,
    output logic                     show_internal_data,
    output logic                     dma_count_width_select
);
    logic             stop_ack_enable;
    logic [2:0]       wake_level_threshold;
    logic [DM_W-1:0]  default_bus_master;
    logic             strap_pending;
    logic             stopped;
    ssp_own_t         owner;
    ssp_own_t         next_owner;
    ssp_own_t         last_internal;
    logic             after_ext;
    logic             ap_valid;
    logic             ap_write;
    logic [ADDR_W-1:0] ap_addr;

    // threshold decode: true when the level may wake the core
    function automatic logic wake_ok(input logic [2:0] thr, input logic [2:0] lvl);
        if (thr == WAKE_NONE) return 1'b0;
        if (thr == WAKE_ANY) return lvl != 3'h0;
        return lvl > thr;
    endfunction : wake_ok

    function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a);
        unique case (a)
            OFS_CLK_CTRL:   return {28'h0000000, wake_level_threshold, stop_ack_enable};
            OFS_PIN_SEL:    return {16'h0000, pin_select};
            OFS_DEF_MASTER: return {24'h000000, default_bus_master};
            OFS_STATUS:     return {28'h0000000, owner == SSP_OWN_EXT, owner == SSP_OWN_DMA,
                                    owner == SSP_OWN_CORE, stopped};
            default:        return 32'h00000000;
        endcase
    endfunction : reg_read

    // bus slave: zero wait states, always okay, unmapped reads zero
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= '0;
        end else if (clk_en && hready) begin
            ap_valid <= hsel && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
            ap_write <= hwrite;
            ap_addr  <= haddr;
        end
    end

    // read data is launched at the address edge so it stands through the whole data phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hrdata <= '0;
        end else if (clk_en && hready && hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
            hrdata <= reg_read(haddr);
        end
    end

    logic wr_en;
    assign wr_en = ap_valid && ap_write && clk_en;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stop_ack_enable      <= 1'b0;
            wake_level_threshold <= WAKE_ANY;
        end else if (wr_en && ap_addr == OFS_CLK_CTRL) begin
            stop_ack_enable      <= hwdata[CC_STOP_EN];
            wake_level_threshold <= hwdata[CC_WAKE_HI:CC_WAKE_LO];
        end
    end

    // strap caught on the first enabled edge after release, a software write wins later
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strap_pending <= 1'b1;
            pin_select    <= '0;
        end else if (clk_en) begin
            strap_pending <= 1'b0;
            if (strap_pending) begin
                pin_select <= {PIN_W{config_strap_pin}};
            end else if (wr_en && ap_addr == OFS_PIN_SEL) begin
                pin_select <= hwdata[PIN_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            default_bus_master <= DM_RESET;
        end else if (wr_en && ap_addr == OFS_DEF_MASTER) begin
            default_bus_master <= hwdata[DM_W-1:0] & DM_WMASK;
        end
    end

    // pin mux: bit n picks port bit n or its alternate function
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin
            assign port_pins_out[gi] = pin_select[gi] ? alt_func_out[gi] : gpio_out[gi];
            assign port_pins_oe[gi]  = pin_select[gi] ? alt_func_dir[gi] : gpio_dir[gi];
            assign alt_func_in[gi]   = pin_select[gi] & port_pins_in[gi];
            assign gpio_in[gi]       = ~pin_select[gi] & port_pins_in[gi];
        end
    endgenerate

    // stop: only the core clock is gated; this block keeps running
    assign wake_event = stopped && wake_ok(wake_level_threshold, irq_level);
    assign stop_ack   = stop_request && stop_ack_enable && !stopped;
    assign core_clk_enable = !stopped;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stopped <= 1'b0;
        end else if (clk_en) begin
            if (wake_event) begin
                stopped <= 1'b0;
            end else if (stop_ack) begin
                stopped <= 1'b1;
            end
        end
    end

    // arbiter
    ssp_park_t park;
    logic      iarb;
    logic      dma_first;
    assign park      = ssp_park_t'(default_bus_master[DM_PARK_HI:DM_PARK_LO]);
    assign iarb      = default_bus_master[DM_IARB];
    assign dma_first = dma_bandwidth_field == BW_MAX;

    always_comb begin
        next_owner = owner;
        if (!bus_busy) begin
            if (iarb && !external_grant_in && ext_targets_internal && !ext_targets_module_base_register) begin
                next_owner = SSP_OWN_EXT;
            end else if (after_ext && core_req) begin
                next_owner = SSP_OWN_CORE;
            end else if (core_req && dma_req) begin
                if (dma_first) begin
                    next_owner = SSP_OWN_DMA;
                end else begin
                    unique case (park)
                        SSP_PARK_RR:   next_owner = last_internal == SSP_OWN_CORE ? SSP_OWN_DMA
                                                                                  : SSP_OWN_CORE;
                        SSP_PARK_CORE: next_owner = SSP_OWN_CORE;
                        SSP_PARK_DMA:  next_owner = SSP_OWN_DMA;
                        SSP_PARK_CUR:  next_owner = owner == SSP_OWN_EXT ? SSP_OWN_CORE : owner;
                    endcase
                end
            end else if (core_req) begin
                next_owner = SSP_OWN_CORE;
            end else if (dma_req) begin
                next_owner = SSP_OWN_DMA;
            end else if (owner == SSP_OWN_EXT) begin
                next_owner = SSP_OWN_CORE;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            owner         <= SSP_OWN_CORE;
            last_internal <= SSP_OWN_CORE;
            after_ext     <= 1'b0;
        end else if (clk_en) begin
            owner <= next_owner;
            if (!bus_busy && next_owner != SSP_OWN_EXT && (core_req || dma_req)) begin
                last_internal <= next_owner;
            end
            if (!bus_busy) begin
                after_ext <= owner == SSP_OWN_EXT && next_owner == SSP_OWN_EXT ? 1'b1
                           : next_owner == SSP_OWN_EXT ? 1'b1 : 1'b0;
            end
        end
    end

    assign core_grant = owner == SSP_OWN_CORE;
    assign dma_grant  = owner == SSP_OWN_DMA;
    assign ext_grant  = owner == SSP_OWN_EXT;
    assign reg_access_external    = default_bus_master[DM_EARB];
    assign show_internal_data     = default_bus_master[DM_SHOW] && default_bus_master[DM_EARB];
    assign dma_count_width_select = default_bus_master[DM_CNT24];

    // checks
    AST_STOP_NEEDS_EN: assert property (@(posedge clk) disable iff (reset)
        $rose(stopped) |-> $past(stop_ack_enable) && $past(stop_request))
        else $error("stop entered without an enabled request");
    AST_STOP_GATE: assert property (@(posedge clk) disable iff (reset)
        (clk_en && stop_request && !stop_ack_enable && !stopped) |=> !stopped)
        else $error("stop entered without enable");
    AST_RESET_EN: assert property (@(posedge clk) $fell(reset) |-> !stop_ack_enable)
        else $error("stop enable not cleared by reset");
    AST_CORE_CLK: assert property (@(posedge clk) disable iff (reset)
        (clk_en && stop_ack) |=> !core_clk_enable)
        else $error("core clock gating wrong");
    AST_NO_WAKE_7: assert property (@(posedge clk) disable iff (reset)
        (stopped && wake_level_threshold == WAKE_NONE && !(wr_en && ap_addr == OFS_CLK_CTRL)) |=> stopped)
        else $error("woke with threshold none");
    sequence s_wake;
        stopped && clk_en && wake_ok(wake_level_threshold, irq_level);
    endsequence
    AST_WAKE: assert property (@(posedge clk) disable iff (reset) s_wake |=> core_clk_enable)
        else $error("core clock not restored");
    AST_PIN_MUX: assert property (@(posedge clk) disable iff (reset)
        port_pins_out == ((pin_select & alt_func_out) | (~pin_select & gpio_out)))
        else $error("pin mux wrong");
    AST_STRAP: assert property (@(posedge clk) disable iff (reset)
        (strap_pending && clk_en) |=> pin_select == {PIN_W{$past(config_strap_pin)}})
        else $error("strap not captured");
    AST_DM_RESET: assert property (@(posedge clk) $fell(reset) |-> default_bus_master == DM_RESET)
        else $error("default master reset wrong");
    AST_NO_REVOKE: assert property (@(posedge clk) disable iff (reset)
        (bus_busy && clk_en) |=> $stable(owner))
        else $error("grant revoked mid transfer");
    AST_EXT_DENIED: assert property (@(posedge clk) disable iff (reset)
        !iarb && !$past(iarb) |-> !(ext_grant && $changed(owner)))
        else $error("external granted while disabled");
    AST_PARK_CORE: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !bus_busy && core_req && park == SSP_PARK_CORE && !dma_first && !after_ext
         && owner != SSP_OWN_EXT && !(iarb && !external_grant_in)) |=> !dma_grant)
        else $error("dma granted over requesting core");
    AST_SHOW: assert property (@(posedge clk) disable iff (reset)
        show_internal_data |-> reg_access_external)
        else $error("show data without register arbitration");

    // round-robin, park and dma-first checks share one opening: free bus, no external claim, no catch-up turn for the core
    sequence s_arb_open;
        clk_en && !bus_busy && !after_ext && !(iarb && !external_grant_in);
    endsequence
    sequence s_both_req;
        core_req && dma_req && !dma_first;
    endsequence
    AST_RR_ALT: assert property (@(posedge clk) disable iff (reset)
        (s_arb_open ##0 s_both_req ##0 park == SSP_PARK_RR) |=> owner != $past(last_internal))
        else $error("round robin did not alternate");
    AST_PARK_DMA: assert property (@(posedge clk) disable iff (reset)
        (s_arb_open ##0 dma_req && park == SSP_PARK_DMA && owner != SSP_OWN_EXT) |=> !core_grant)
        else $error("core granted over requesting dma");
    AST_PARK_CUR: assert property (@(posedge clk) disable iff (reset)
        (s_arb_open ##0 s_both_req ##0 park == SSP_PARK_CUR && owner != SSP_OWN_EXT) |=> $stable(owner))
        else $error("current owner lost the bus while requesting");
    AST_DMA_FIRST: assert property (@(posedge clk) disable iff (reset)
        (s_arb_open ##0 dma_req && dma_first) |=> dma_grant)
        else $error("dma at maximum bandwidth not granted");
    AST_EXT_FIRST: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !bus_busy && iarb && !external_grant_in && ext_targets_internal && !ext_targets_module_base_register)
        |=> ext_grant)
        else $error("external master not ranked highest");
    AST_EXT_HELD_OFF: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !bus_busy && external_grant_in && owner != SSP_OWN_EXT) |=> !ext_grant)
        else $error("external master granted while grant asserted");
    AST_MODULE_BASE_REGISTER_CORE: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !bus_busy && ext_targets_module_base_register && owner != SSP_OWN_EXT) |=> !ext_grant)
        else $error("external master reached the base register");

    // stop, register and pin input routing checks
    AST_ANY_WAKE: assert property (@(posedge clk) disable iff (reset)
        (stopped && clk_en && wake_level_threshold == WAKE_ANY && irq_level != 3'h0) |=> !stopped)
        else $error("pending interrupt did not wake with threshold any");
    AST_CLK_WR: assert property (@(posedge clk) disable iff (reset)
        (wr_en && ap_addr == OFS_CLK_CTRL) |=> wake_level_threshold == $past(hwdata[CC_WAKE_HI:CC_WAKE_LO]))
        else $error("wake threshold write lost");
    AST_PIN_WR: assert property (@(posedge clk) disable iff (reset)
        (wr_en && ap_addr == OFS_PIN_SEL && !strap_pending) |=> pin_select == $past(hwdata[PIN_W-1:0]))
        else $error("pin select write lost");
    AST_PIN_IN: assert property (@(posedge clk) disable iff (reset)
        alt_func_in == (pin_select & port_pins_in) && gpio_in == (~pin_select & port_pins_in))
        else $error("pin input routing wrong");
    sequence s_read_addr(logic [ADDR_W-1:0] a);
        clk_en && hready && hsel && htrans == HTRANS_NONSEQ && !hwrite && haddr == a;
    endsequence
    AST_RD_DEF: assert property (@(posedge clk) disable iff (reset)
        s_read_addr(OFS_DEF_MASTER) |=> hrdata == {24'h000000, $past(default_bus_master)})
        else $error("default master read wrong");
    AST_STATUS_RD: assert property (@(posedge clk) disable iff (reset)
        s_read_addr(OFS_STATUS) |=> hrdata[3:1] == {$past(ext_grant), $past(dma_grant), $past(core_grant)})
        else $error("owner status read wrong");
endmodule : ssp_ctrl

// ### tb/ssp_masters_model.sv
// behavioural core and dma masters: hold requests, run fixed-length transfers once granted
`timescale 1ns/100ps
module ssp_masters_model
    import ssp_pkg::*;
#(
    parameter int XFER_LEN = 2
)(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic core_want,
    input  wire logic dma_want,
    input  wire logic core_grant,
    input  wire logic dma_grant,
    output logic      core_req,
    output logic      dma_req,
    output logic      bus_busy
);
    int unsigned left;

    assign core_req = core_want;
    assign dma_req  = dma_want;
    assign bus_busy = (left != 0);

    // one idle cycle between transfers gives the arbiter a decision point
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            left <= 0;
        end else if (left != 0) begin
            left <= left - 1;
        end else if ((core_grant && core_req) || (dma_grant && dma_req)) begin
            left <= XFER_LEN;
        end
    end
endmodule : ssp_masters_model

// ### tb/tb.sv
// testbench: register access over ahb-lite, stop and wake, pin mux and arbitration scenarios
`timescale 1ns/100ps
module tb
    import ssp_pkg::*;
;
    logic        clk, reset, clk_en, hsel, hwrite, stop_request, config_strap_pin, woke, exp;
    logic        core_want, dma_want, external_grant_in, ext_targets_internal, ext_targets_module_base_register;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, irq_level, dma_bandwidth_field;
    logic [31:0] hwdata, hrdata, rd;
    logic        hreadyout, hresp, stop_ack, core_clk_enable, wake_event, core_req, dma_req, bus_busy;
    logic        core_grant, dma_grant, ext_grant, reg_access_external, show_internal_data, dma_count_width_select;
    logic [15:0] pin_select, port_pins_out, port_pins_oe, port_pins_in, alt_func_out, alt_func_dir;
    logic [15:0] gpio_out, gpio_dir, alt_func_in, gpio_in;
    int          errors, total_checks, n_core, n_dma, n_ext, n_sw;

    ssp_ctrl i_dut (.*, .hready(hreadyout));
    ssp_masters_model #(.XFER_LEN(2)) i_masters (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] expv);
        total_checks++;
        if (got !== expv) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, expv);
        end
    endtask : check

    task automatic end_of_test();
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // address phase held until hready, then data phase held until hready again
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (hreadyout !== 1'b1 && n < 50);
            if (hreadyout !== 1'b1) begin
                errors++;
                end_of_test();
            end
            if (ph == 0) begin
                htrans <= 2'h0;
                hwdata <= wd;
            end
        end
        rd = hrdata;
        hsel <= 1'b0;
    endtask : bus

    task automatic do_reset(input logic strap);
        config_strap_pin <= strap;
        reset <= 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(pin_select, {16{strap}});
        bus(1'b0, OFS_DEF_MASTER, 32'h0);
        check(rd, {24'h0, DM_RESET});
    endtask : do_reset

    task automatic stop_try(input logic en);
        @(posedge clk);
        stop_request <= 1'b1;
        @(negedge clk);
        check(stop_ack, en);
        @(posedge clk);
        stop_request <= 1'b0;
        @(negedge clk);
        check(core_clk_enable, !en);
    endtask : stop_try

    // settles, then counts grants and core-grant changes over a window
    task automatic arb_run(input logic [7:0] dm, input logic cw, input logic dw);
        logic pc;
        bus(1'b1, OFS_DEF_MASTER, {24'h0, dm});
        core_want <= cw;
        dma_want <= dw;
        repeat (8) @(posedge clk);
        {n_core, n_dma, n_ext, n_sw} = '0;
        pc = core_grant;
        repeat (30) begin
            @(negedge clk);
            n_core += core_grant;
            n_dma += dma_grant;
            n_ext += ext_grant;
            n_sw += (core_grant != pc);
            pc = core_grant;
        end
        @(posedge clk);
    endtask : arb_run

    initial begin
        {reset, clk_en, hsel, hwrite, stop_request, core_want, dma_want, ext_targets_internal} = 8'h41;
        {ext_targets_module_base_register, external_grant_in, config_strap_pin} = 3'h3;
        {haddr, htrans, hsize, irq_level, hwdata} = '0;
        dma_bandwidth_field = 3'h1;
        {gpio_out, gpio_dir, alt_func_out, alt_func_dir, port_pins_in} = 80'h1234_0f0f_abcd_f0f0_5a5a;
        {errors, total_checks} = '0;
        do_reset(1'b1);
        bus(1'b0, OFS_CLK_CTRL, 32'h0);
        check(rd[CC_STOP_EN], 1'b0);
        bus(1'b1, OFS_PIN_SEL, 32'h00a5);
        bus(1'b0, OFS_PIN_SEL, 32'h0);
        check(rd, 32'h00a5);
        check(port_pins_out, (16'habcd & 16'h00a5) | (16'h1234 & 16'hff5a));
        check(port_pins_oe, (16'hf0f0 & 16'h00a5) | (16'h0f0f & 16'hff5a));
        check(alt_func_in, 16'h00a5 & 16'h5a5a);
        check(gpio_in, 16'hff5a & 16'h5a5a);
        clk_en <= 1'b0;
        bus(1'b1, OFS_PIN_SEL, 32'h1234);
        clk_en <= 1'b1;
        bus(1'b0, OFS_PIN_SEL, 32'h0);
        check(rd, 32'h00a5);
        bus(1'b1, 8'h08, 32'hffff_ffff);
        bus(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        check(hresp, 1'b0);
        bus(1'b1, OFS_DEF_MASTER, 32'hff);
        bus(1'b0, OFS_DEF_MASTER, 32'h0);
        check(rd, {24'h0, DM_WMASK});
        check({reg_access_external, show_internal_data, dma_count_width_select}, 3'h7);
        bus(1'b1, OFS_DEF_MASTER, 32'h08);
        @(negedge clk);
        check({reg_access_external, show_internal_data}, 2'h0);
        stop_try(1'b0);
        for (int t = 0; t < 8; t++) begin
            bus(1'b1, OFS_CLK_CTRL, {28'h0, t[2:0], 1'b1});
            stop_try(1'b1);
            bus(1'b0, OFS_STATUS, 32'h0);
            check(rd[0], 1'b1);
            woke = 1'b0;
            for (int l = 0; l < 8 && !woke; l++) begin
                @(posedge clk);
                irq_level <= l[2:0];
                @(negedge clk);
                exp = (t == 0) ? (l != 0) : (t != 7 && l > t);
                check(wake_event, exp);
                if (exp) begin
                    @(negedge clk);
                    check(core_clk_enable, 1'b1);
                    woke = 1'b1;
                end
            end
            @(posedge clk);
            irq_level <= 3'h0;
            if (!woke) begin
                bus(1'b1, OFS_CLK_CTRL, 32'h1);
                irq_level <= 3'h1;
                repeat (2) @(negedge clk);
                check(core_clk_enable, 1'b1);
                @(posedge clk);
                irq_level <= 3'h0;
            end
        end
        arb_run(8'h00, 1'b1, 1'b1);
        check(n_core > 0 && n_dma > 0 && n_sw >= 4, 1'b1);
        arb_run(8'h40, 1'b1, 1'b1);
        check(n_dma, 0);
        arb_run(8'h40, 1'b0, 1'b1);
        check(n_dma > 0, 1'b1);
        arb_run(8'h80, 1'b1, 1'b1);
        check(n_core, 0);
        arb_run(8'hc0, 1'b1, 1'b1);
        check(n_sw, 0);
        dma_bandwidth_field <= BW_MAX;
        arb_run(8'h40, 1'b1, 1'b1);
        check(n_dma > 0, 1'b1);
        dma_bandwidth_field <= 3'h1;
        external_grant_in <= 1'b0;
        ext_targets_internal <= 1'b1;
        arb_run(8'h00, 1'b1, 1'b0);
        check(n_ext, 0);
        ext_targets_module_base_register <= 1'b1;
        arb_run(8'h20, 1'b1, 1'b0);
        check(n_ext, 0);
        ext_targets_module_base_register <= 1'b0;
        arb_run(8'h20, 1'b1, 1'b0);
        check(n_ext > 0, 1'b1);
        bus(1'b0, OFS_STATUS, 32'h0);
        check(rd, 32'h8);
        external_grant_in <= 1'b1;
        ext_targets_internal <= 1'b0;
        do_reset(1'b0);
        end_of_test();
    end
endmodule : tb
